// File: core/spm_port.sv
// Six-bit general-purpose port with pin multiplexing on pins 5 to 3
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`include "spm_regs.svh"
module spm_port (
    // Clock and reset
    input  wire logic                     clock_i,
    input  wire logic                     rst_n_i,
    // Register port
    input  wire logic [`SPM_ADDR_W-1:0]   addr_i,
    input  wire logic [31:0]              wdata_i,
    input  wire logic                     wr_i,
    input  wire logic                     rd_i,
    output logic      [31:0]              rdata_o,
    // Peripheral units
    input  wire spm_pkg::spm_periph_t     periph_i,
    output logic                          serial1_clock_in_o,
    output logic                          serial1_receive_in_o,
    output logic                          i2c0_clock_in_o,
    output logic                          i2c0_data_in_o,
    output logic                          i2c1_clock_in_o,
    output logic                          ext_interrupt_5_o,
    // Pads
    input  wire logic [5:0]               pin_i,
    output spm_pkg::spm_pad_t             pad_o
);
    import spm_pkg::*;

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic [1:0] rst_sync;
    logic       rst_n;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ----------------------------------------
    // Pin input synchroniser
    // ----------------------------------------
    logic [5:0] pin_meta;
    logic [5:0] pin_sync;
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= `SPM_PORT_RST;
            pin_sync <= `SPM_PORT_RST;
        end else begin
            pin_meta <= pin_i;
            pin_sync <= pin_meta;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [5:0] port_direction;
    logic [5:0] port_output_data;
    logic [5:0] port_open_drain_select;
    logic [4:0] serial_ctrl;
    logic [1:0] i2c_ctrl;

    // Port registers keep bits 5..0, serial control 4..0, I2C control 1..0; upper write bits fall away
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            port_direction         <= `SPM_PORT_RST; // R14
            port_output_data       <= `SPM_PORT_RST; // R1
            port_open_drain_select <= `SPM_PORT_RST; // R5
            serial_ctrl            <= `SPM_SER_RST;
            i2c_ctrl               <= `SPM_I2C_RST;
        end else if (wr_i) begin
            unique case (addr_i)
                `SPM_OFS_DIRECTION: port_direction         <= wdata_i[5:0]; // R14
                `SPM_OFS_DATA:      port_output_data       <= wdata_i[5:0]; // R15
                `SPM_OFS_OPEN_DRN:  port_open_drain_select <= wdata_i[5:0]; // R15
                `SPM_OFS_SER_CTRL:  serial_ctrl            <= wdata_i[4:0];
                `SPM_OFS_I2C_CTRL:  i2c_ctrl               <= wdata_i[1:0];
                default: ; // Pin-state writes land here and are dropped  R4
            endcase
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    logic [5:0] pin_state;
    // Output pins read back the latch, inputs read the pad  R2 R3
    assign pin_state = (port_direction & port_output_data) | (~port_direction & pin_sync); // R2 R3

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_o <= `SPM_UNDEF_WORD;
        end else if (rd_i) begin
            unique case (addr_i)
                `SPM_OFS_DATA:      rdata_o <= {`SPM_WORD_PAD, `SPM_UNUSED_HI, port_output_data}; // R15
                `SPM_OFS_PIN_STATE: rdata_o <= {`SPM_WORD_PAD, `SPM_UNUSED_HI, pin_state};
                `SPM_OFS_OPEN_DRN:  rdata_o <= {`SPM_WORD_PAD, `SPM_UNUSED_HI, port_open_drain_select};
                `SPM_OFS_SER_CTRL:  rdata_o <= {27'h000_0000, serial_ctrl};
                `SPM_OFS_I2C_CTRL:  rdata_o <= {30'h0000_0000, i2c_ctrl};
                // Direction is write-only; undefined data reads as zero  R14
                default:            rdata_o <= `SPM_UNDEF_WORD;
            endcase
        end else begin
            rdata_o <= `SPM_UNDEF_WORD;
        end
    end

    // ----------------------------------------
    // Pin function selection
    // ----------------------------------------
    logic clock_enable_0, clock_enable_1, sync_mode, rx_en, tx_en, i2c0_en, i2c1_en;
    assign clock_enable_0      = serial_ctrl[`SPM_SER_CLOCK_ENABLE_0];
    assign clock_enable_1      = serial_ctrl[`SPM_SER_CLOCK_ENABLE_1];
    assign sync_mode = serial_ctrl[`SPM_SER_SYNC];
    assign rx_en     = serial_ctrl[`SPM_SER_RE];
    assign tx_en     = serial_ctrl[`SPM_SER_TE];
    assign i2c0_en   = i2c_ctrl[`SPM_I2C0_EN];
    assign i2c1_en   = i2c_ctrl[`SPM_I2C1_EN];

    // Drive value d with open-drain bit od: open drain releases the pad for a high
    function automatic logic [1:0] drive(input logic d, input logic od);
        drive = {d, od ? ~d : 1'b1}; // R5
    endfunction

    spm_pad_t next_pad;
    always_comb begin
        logic [1:0] dv;
        dv       = 2'b00;
        next_pad = '0;
        // Pins 2..0: general I/O only in this block
        for (int i = 0; i < 3; i++) begin
            dv = drive(port_output_data[i], port_open_drain_select[i]);
            next_pad.out[i] = dv[1];
            next_pad.oe[i]  = port_direction[i] & dv[0]; // R1
        end
        // Pin 5
        if (!i2c0_en && !clock_enable_1 && !clock_enable_0 && !sync_mode) begin
            dv = drive(port_output_data[`SPM_PIN5], port_open_drain_select[`SPM_PIN5]); // R6
            next_pad.out[`SPM_PIN5] = dv[1];
            next_pad.oe[`SPM_PIN5]  = port_direction[`SPM_PIN5] & dv[0]; // R6 R1
        end else if (!i2c0_en && !clock_enable_1) begin
            dv = drive(periph_i.ser_clk_out, port_open_drain_select[`SPM_PIN5]); // R7 R9
            next_pad.out[`SPM_PIN5] = dv[1];
            next_pad.oe[`SPM_PIN5]  = dv[0];
        end else if (i2c0_en && !clock_enable_1 && !clock_enable_0 && !sync_mode) begin
            next_pad.out[`SPM_PIN5] = 1'b0; // R8
            next_pad.oe[`SPM_PIN5]  = periph_i.i2c0_scl_low;
        end
        // Clock-input case (clock_enable_1) and illegal mixes leave pin 5 undriven  R7
        // Pin 4
        if (i2c0_en) begin
            next_pad.out[`SPM_PIN4] = 1'b0; // R10
            next_pad.oe[`SPM_PIN4]  = periph_i.i2c0_sda_low;
        end else if (!rx_en) begin
            dv = drive(port_output_data[`SPM_PIN4], port_open_drain_select[`SPM_PIN4]); // R11
            next_pad.out[`SPM_PIN4] = dv[1];
            next_pad.oe[`SPM_PIN4]  = port_direction[`SPM_PIN4] & dv[0]; // R10
        end
        // Pin 3
        if (i2c1_en) begin
            next_pad.out[`SPM_PIN3] = 1'b0; // R12
            next_pad.oe[`SPM_PIN3]  = periph_i.i2c1_scl_low;
        end else if (tx_en) begin
            next_pad.out[`SPM_PIN3] = periph_i.ser_txd; // R12
            next_pad.oe[`SPM_PIN3]  = 1'b1;
        end else begin
            dv = drive(port_output_data[`SPM_PIN3], port_open_drain_select[`SPM_PIN3]); // R13
            next_pad.out[`SPM_PIN3] = dv[1];
            next_pad.oe[`SPM_PIN3]  = port_direction[`SPM_PIN3] & dv[0];
        end
    end

    // Registered pad drive keeps outputs glitch-free at the cost of one cycle
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            pad_o <= '0;
        end else begin
            pad_o <= next_pad;
        end
    end

    // ----------------------------------------
    // Inputs to peripheral units
    // ----------------------------------------
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            serial1_clock_in_o   <= 1'b0;
            serial1_receive_in_o <= 1'b0;
            i2c0_clock_in_o      <= 1'b0;
            i2c0_data_in_o       <= 1'b0;
            i2c1_clock_in_o      <= 1'b0;
            ext_interrupt_5_o    <= 1'b0;
        end else begin
            serial1_clock_in_o   <= pin_sync[`SPM_PIN5] & ~i2c0_en & clock_enable_1; // R7
            serial1_receive_in_o <= pin_sync[`SPM_PIN4] & ~i2c0_en & rx_en; // R10
            i2c0_clock_in_o      <= pin_sync[`SPM_PIN5]; // R8
            i2c0_data_in_o       <= pin_sync[`SPM_PIN4];
            i2c1_clock_in_o      <= pin_sync[`SPM_PIN3];
            ext_interrupt_5_o    <= pin_sync[`SPM_PIN5]; // R9
        end
    end
endmodule

// File: core/spm_regs.svh
// Register offsets, field positions and reset values of the six-bit port
`ifndef SPM_REGS_SVH
`define SPM_REGS_SVH
// Behaviour
// R1: Six output-data bits, cleared at reset, drive pins only as general-purpose outputs.
// R2: Pin-state read returns stored output data where the direction bit is 1.
// R3: Pin-state read returns the sampled pin level where the direction bit is 0.
// R4: Pin-state register is read-only; writes change nothing.
// R5: Open-drain bit 1 drives low only; 0 gives push-pull; cleared at reset.
// R6: Pin 5 is general I/O only with I2C 0 off, async mode, clock enables 0.
// R7: With I2C 0 off, pin 5 carries serial clock in or out per clock enables/mode.
// R8: I2C 0 enabled and serial clock bits all 0 makes pin 5 the I2C 0 clock.
// R9: Pin 5 always feeds interrupt 5; open-drain bit covers GPIO and serial clock out.
// R10: Pin 4 is I2C 0 data, else serial receive, else general I/O.
// R11: Pin 4 general output honours its open-drain bit.
// R12: Pin 3 is I2C 1 clock, else serial transmit, else general I/O.
// R13: Pin 3 general output honours its open-drain bit.
// R14: Direction bits write-only, 1 output, 0 input, cleared at reset, read undefined.
// R15: Bits 7 and 6 of data, pin-state, open-drain ignore writes, read fixed.

// ----------------------------------------
// Register map (byte addresses, one word each)
// ----------------------------------------
`define SPM_ADDR_W        8
`define SPM_OFS_DIRECTION 8'h00
`define SPM_OFS_DATA      8'h04
`define SPM_OFS_PIN_STATE 8'h08
`define SPM_OFS_OPEN_DRN  8'h0C
`define SPM_OFS_SER_CTRL  8'h10
`define SPM_OFS_I2C_CTRL  8'h14

// ----------------------------------------
// Fields
// ----------------------------------------
`define SPM_NPINS         6
`define SPM_PORT_RST      6'h00
`define SPM_UNUSED_HI     2'h0
`define SPM_WORD_PAD      24'h00_0000
`define SPM_UNDEF_WORD    32'h0000_0000
`define SPM_SER_RST       5'h00
`define SPM_I2C_RST       2'h0
// Serial control word: bit0 clock_enable_0, bit1 clock_enable_1, bit2 sync mode,
// bit3 receive_enable, bit4 transmit_enable
`define SPM_SER_CLOCK_ENABLE_0      0
`define SPM_SER_CLOCK_ENABLE_1      1
`define SPM_SER_SYNC      2
`define SPM_SER_RE        3
`define SPM_SER_TE        4
// I2C control word: bit0 channel 0 enable, bit1 channel 1 enable
`define SPM_I2C0_EN       0
`define SPM_I2C1_EN       1
`define SPM_PIN5          5
`define SPM_PIN4          4
`define SPM_PIN3          3
`endif

// File: core/spm_pkg.sv
// Types shared by the six-bit port
package spm_pkg;
    // Per-pin drive request toward the pad
    typedef struct packed {
        logic [5:0] out;
        logic [5:0] oe;
    } spm_pad_t;

    // Signals from the peripheral units sharing pins 5 to 3
    typedef struct packed {
        logic ser_clk_out;
        logic ser_txd;
        logic i2c0_scl_low;
        logic i2c0_sda_low;
        logic i2c1_scl_low;
    } spm_periph_t;
endpackage

// File: tb/spm_pin_model.sv
// Circuitry outside the pads: pull-ups plus peers that may pull a line low
`timescale 1ns/100ps
module spm_pin_model import spm_pkg::*; (
    // Pad side
    input  wire spm_pad_t   pad_i,
    input  wire logic [5:0] ext_low_i,
    output logic      [5:0] pin_o
);
    // A released line floats high; any low driver wins, as on a wired-AND line
    assign pin_o = ~((pad_i.oe & ~pad_i.out) | ext_low_i);
endmodule

// File: tb/spm_port_checker.sv
// Port checker: register reads, pad drive and pin sampling
`timescale 1ns/100ps
module spm_port_checker import spm_pkg::*; (
    // Clock, reset and register port
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    input wire logic [7:0]  addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [31:0] rdata_o,
    // Peripherals and pads
    input wire spm_periph_t periph_i,
    input wire logic        i2c0_clock_in_o,
    input wire logic        i2c0_data_in_o,
    input wire logic        i2c1_clock_in_o,
    input wire logic        ext_interrupt_5_o,
    input wire logic [5:0]  pin_i,
    input wire spm_pad_t    pad_o
);
    logic [3:0] up;
    logic [5:0] dir, dat, odr;
    logic [4:0] ser;
    logic [1:0] icr;
    // Shadow registers; checks wait until the internal reset copy has surely lifted
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {up, dir, dat, odr, ser, icr} <= '0;
        end else begin
            if (!up[3]) up <= up + 4'h1;
            if (wr_i && addr_i == 8'h00) dir <= wdata_i[5:0];
            if (wr_i && addr_i == 8'h04) dat <= wdata_i[5:0];
            if (wr_i && addr_i == 8'h0C) odr <= wdata_i[5:0];
            if (wr_i && addr_i == 8'h10) ser <= wdata_i[4:0];
            if (wr_i && addr_i == 8'h14) icr <= wdata_i[1:0];
        end
    end
    wire m5i = icr[0] & ~|ser[2:0];
    wire m5c = ~icr[0] & ~ser[1] & (ser[0] | ser[2]);
    wire m5g = ~icr[0] & ~|ser[2:0];
    wire [5:0] v = {m5i ? ~periph_i.i2c0_scl_low : m5c ? periph_i.ser_clk_out : dat[5],
        icr[0] ? ~periph_i.i2c0_sda_low : dat[4],
        icr[1] ? ~periph_i.i2c1_scl_low : ser[4] ? periph_i.ser_txd : dat[3], dat[2:0]};
    wire [5:0] f = {m5i | m5c | m5g & dir[5], icr[0] | ~ser[3] & dir[4], icr[1] | ser[4] | dir[3], dir[2:0]};
    wire [5:0] od = {m5i | odr[5], icr[0] | odr[4], icr[1] | odr[3], odr[2:0]};
    // Open-drain use on the transmit output is left open, so that case is masked
    wire [5:0] chk = {2'b11, ~(~icr[1] & ser[4] & odr[3]), 3'b111};
    wire [5:0] eoe = f & (~od | ~v);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!up[3]);
    a_rd_hi_zero: assert property ($past(rd_i) |-> rdata_o[31:6] == 26'h000_0000)
        else $error("upper read bits not zero");
    a_data_rd: assert property ($past(rd_i && addr_i == 8'h04) |-> rdata_o[5:0] == $past(dat))
        else $error("data read wrong");
    a_odr_rd: assert property ($past(rd_i && addr_i == 8'h0C) |-> rdata_o[5:0] == $past(odr))
        else $error("open-drain read wrong");
    a_dir_rd: assert property (rd_i && addr_i == 8'h00 |=> rdata_o == 32'h0000_0000)
        else $error("direction read not zero");
    a_pin_rd: assert property (rd_i && addr_i == 8'h08 && pin_i == $past(pin_i) && pin_i == $past(pin_i, 2)
        && pin_i == $past(pin_i, 3) |=> rdata_o[5:0] == $past(dir & dat | ~dir & pin_i))
        else $error("pin state read wrong");
    a_pad_enable: assert property ((pad_o.oe & $past(chk)) == $past(eoe & chk))
        else $error("pad enable wrong");
    a_pad_value: assert property ((pad_o.out & pad_o.oe & $past(chk)) == $past(v & eoe & chk))
        else $error("pad value wrong");
    a_sync_follow: assert property (pin_i[5:3] == $past(pin_i[5:3]) && pin_i[5:3] == $past(pin_i[5:3], 2)
        && pin_i[5:3] == $past(pin_i[5:3], 3) |-> {ext_interrupt_5_o, i2c0_clock_in_o, i2c0_data_in_o,
        i2c1_clock_in_o} == {pin_i[5], pin_i[5:3]})
        else $error("sampled pin copies wrong");
    c_pin_wr: cover property (wr_i && addr_i == 8'h08);
    c_i2c_low: cover property (m5i && periph_i.i2c0_scl_low);
    c_sclk_out: cover property (m5c && pad_o.oe[5]);
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the six-bit port
`timescale 1ns/100ps
module tb_top;
    import spm_pkg::*;
    logic        clock_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [7:0]  addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0000_0000;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [31:0] rdata_o;
    spm_periph_t periph_i = 5'h14;
    logic [5:0]  ext_low = 6'h00;
    logic [5:0]  pin_i;
    spm_pad_t    pad_o;
    logic        sck_in, rx_in, i2c0_clock_line_in, i2c0_data_line_in, i2c1_clock_line_in, ext_interrupt_5;
    int          fails = 0;
    int          n_compared = 0;
    always #2.5 clock_i = ~clock_i;
    spm_port dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .periph_i(periph_i), .serial1_clock_in_o(sck_in),
        .serial1_receive_in_o(rx_in), .i2c0_clock_in_o(i2c0_clock_line_in), .i2c0_data_in_o(i2c0_data_line_in),
        .i2c1_clock_in_o(i2c1_clock_line_in), .ext_interrupt_5_o(ext_interrupt_5), .pin_i(pin_i), .pad_o(pad_o));
    spm_pin_model pins_u (.pad_i(pad_o), .ext_low_i(ext_low), .pin_o(pin_i));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
        @(posedge clock_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 chk(nm, e, rdata_o);
    endtask
    // Waits out the pad register and the pin synchroniser before looking
    task automatic padc(input logic [5:0] oe, input logic [5:0] out);
        repeat (6) @(posedge clock_i);
        #1 chk("pad_oe", {26'h000_0000, oe}, {26'h000_0000, pad_o.oe});
        chk("pad_out", {26'h000_0000, out}, {26'h000_0000, pad_o.out & pad_o.oe});
    endtask
    task automatic mux(input logic [4:0] s, input logic [1:0] i, input logic [5:0] oe, input logic [5:0] out,
                       input logic [2:0] fl);
        wr(8'h10, {27'h000_0000, s});
        wr(8'h14, {30'h0000_0000, i});
        padc(oe, out);
        chk("sck_rx_irq", {29'h0000_0000, fl}, {29'h0000_0000, sck_in, rx_in, ext_interrupt_5});
    endtask
    task automatic t_reset;
        padc(6'h00, 6'h00);
        rdc(8'h04, 32'h0000_0000, "data");
        rdc(8'h0C, 32'h0000_0000, "odr");
        rdc(8'h08, 32'h0000_003F, "pins");
        $display("test reset done");
    endtask
    task automatic t_gpio;
        wr(8'h00, 32'h0000_003F);
        wr(8'h04, 32'hFFFF_FFEA);
        padc(6'h3F, 6'h2A);
        rdc(8'h04, 32'h0000_002A, "data");
        wr(8'h08, 32'h0000_0015);
        ext_low <= 6'h02;
        padc(6'h3F, 6'h2A);
        rdc(8'h08, 32'h0000_002A, "pins");
        rdc(8'h00, 32'h0000_0000, "dir");
        ext_low <= 6'h00;
        $display("test gpio done");
    endtask
    task automatic t_od;
        wr(8'h0C, 32'hFFFF_FFFF);
        padc(6'h15, 6'h00);
        rdc(8'h0C, 32'h0000_003F, "odr");
        wr(8'h00, 32'h0000_0000);
        ext_low <= 6'h0F;
        padc(6'h00, 6'h00);
        rdc(8'h08, 32'h0000_0030, "pins");
        ext_low <= 6'h00;
        wr(8'h0C, 32'h0000_0000);
        $display("test open drain done");
    endtask
    task automatic t_mux;
        wr(8'h00, 32'h0000_003F);
        wr(8'h04, 32'h0000_0000);
        mux(5'h00, 2'h0, 6'h3F, 6'h00, 3'h0);
        mux(5'h01, 2'h0, 6'h3F, 6'h20, 3'h1);
        mux(5'h02, 2'h0, 6'h1F, 6'h00, 3'h5);
        mux(5'h04, 2'h0, 6'h3F, 6'h20, 3'h1);
        wr(8'h0C, 32'h0000_0020);
        mux(5'h01, 2'h0, 6'h1F, 6'h00, 3'h1);
        wr(8'h0C, 32'h0000_0000);
        mux(5'h08, 2'h0, 6'h2F, 6'h00, 3'h2);
        mux(5'h10, 2'h0, 6'h3F, 6'h00, 3'h0);
        mux(5'h00, 2'h1, 6'h2F, 6'h00, 3'h0);
        mux(5'h01, 2'h1, 6'h0F, 6'h00, 3'h1);
        mux(5'h00, 2'h2, 6'h37, 6'h00, 3'h0);
        $display("test pin functions done");
    endtask
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (5) @(posedge clock_i);
        t_reset();
        t_gpio();
        t_od();
        t_mux();
        summarize();
    end
    // The whole sequence needs well under a thousand cycles
    initial begin
        #20000;
        fails++;
        summarize();
    end
endmodule
bind spm_port spm_port_checker chk_u (.clock_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .periph_i,
    .i2c0_clock_in_o, .i2c0_data_in_o, .i2c1_clock_in_o, .ext_interrupt_5_o, .pin_i, .pad_o);
